// ### core/riom_core.sv
// Receive IO pin mapping, continuous data delivery and packet framer.
// What this block does
// - Six pins, each picks signal by 2-bit code.
// - Continuous receive codes 00 and 01 routing.
// - Continuous receive codes 10 and 11 routing.
// - Continuous non-receive routing per code and mode.
// - Packet non-receive routing per code and mode.
// - Packet receive codes 00 and 01 routing.
// - Packet receive codes 10 and 11 routing.
// - Packet data shown only between ready and done.
// - Continuous mode: direct bits, packet handler idle.
// - No bit sync: raw data, no clock.
// - Bit sync: data changes on falling clock.
// - Packet mode: forced bit sync, data buffered.
// - Buffer readable in sleep or standby.
// - Fixed format: select 0, nonzero length.
// - Fixed limits: 255, or 64 message decrypted.
// - Variable format: first byte gives length.
// - Variable limits: 255, or 64 message decrypted.
// - Unlimited format: select 0, length 0.
// - Unlimited: no checksum, no done flags.
// - Unlimited without sync: no address filtering.
// - Frame: preamble, sync, length, address, message, checksum.
// - Receive buffer holds 66 bytes.
// - Variable: discard length above setting.
// - Address is first body byte after length.
`timescale 1ns/100ps
`include "riom_map.svh"

module riom_core import riom_pkg::*; (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire riom_mode_t op_mode,
  input wire logic packet_mode,
  input wire logic bit_sync_en,
  input wire logic [7:0] io_map_reg_1,
  input wire logic [7:0] io_map_reg_2,
  input wire riom_flags_t status_flags,
  input wire riom_pkt_cfg_t pkt_cfg,
  input wire logic rd_req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic io_pin_0,
  output logic io_pin_1,
  output logic io_pin_2,
  output logic io_pin_3,
  output logic io_pin_4,
  output logic io_pin_5,
  input wire logic link_clk,
  input wire logic link_bit,
  input wire logic link_bit_valid,
  input wire logic link_sync_hit
);

  function automatic logic [1:0] map_code(input int p, input logic [7:0] r1, input logic [7:0] r2);
    logic [1:0] c;
    if (p < 4) begin
      c = r1[`RIOM_MAP_TOP - 2 * p -: 2];
    end else begin
      c = r2[`RIOM_MAP_TOP - 2 * (p - 4) -: 2];
    end
    return c;
  endfunction

  function automatic riom_sig_t pin_sel(input int p, input logic [1:0] code, input riom_mode_t m, input logic pkt);
    riom_sig_t t [6];
    logic fs;
    fs = (m == mode_fs);
    for (int i = 0; i < 6; i++) begin
      t[i] = sig_none;
    end
    if (m == mode_rx) begin
      case ({pkt, code})
        3'h0: t = '{sig_sync, sig_dclk, sig_data, sig_rssi, sig_tmo, sig_clk};
        3'h1: t = '{sig_tmo, sig_rxrdy, sig_data, sig_rxrdy, sig_rxrdy, sig_rssi};
        3'h2: t = '{sig_rssi, sig_lbat, sig_data, sig_auto, sig_sync, sig_lbat};
        3'h3: t = '{sig_mrdy, sig_sync, sig_data, sig_tmo, sig_pll, sig_mrdy};
        3'h4: t = '{sig_crc, sig_flvl, sig_fne, sig_ffull, sig_tmo, sig_clk};
        3'h5: t = '{sig_pdone, sig_ffull, sig_data, sig_rssi, sig_rssi, sig_data};
        3'h6: t = '{sig_sync, sig_fne, sig_lbat, sig_sync, sig_rxrdy, sig_lbat};
        default: t = '{sig_rssi, sig_tmo, sig_auto, sig_pll, sig_pll, sig_mrdy};
      endcase
    end else begin
      case ({pkt, code})
        3'h0: begin
          t[5] = sig_clk;
          if (fs) begin
            t[0] = sig_pll;
          end
        end
        3'h2: t = '{sig_lbat, sig_lbat, sig_none, sig_auto, sig_lbat, sig_lbat};
        3'h3: begin
          t[5] = sig_mrdy;
          t[0] = sig_mrdy;
          if (fs) begin
            t[4] = sig_pll;
            t[1] = sig_pll;
          end
        end
        3'h4: t = '{sig_none, sig_flvl, sig_fne, sig_ffull, sig_none, sig_clk};
        3'h5: t[1] = sig_ffull;
        3'h6: t = '{sig_lbat, sig_fne, sig_lbat, sig_lbat, sig_lbat, sig_lbat};
        3'h7: begin
          t[5] = sig_mrdy;
          t[2] = sig_auto;
          if (fs) begin
            t[0] = sig_pll;
            t[1] = sig_pll;
            t[3] = sig_pll;
            t[4] = sig_pll;
          end
        end
        default: ;
      endcase
    end
    return t[p];
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ({r[14:0], 1'b0} ^ `RIOM_CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  // Reset release, one copy per clock domain.
  logic rst_meta, rst_n, lrst_meta, lrst_n;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      lrst_meta <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_meta <= 1'b1;
      lrst_n <= lrst_meta;
    end
  end

  // Link side: byte assembly aligned to the sync hit, bit and event toggles.
  logic [7:0] shift, byte_hold;
  logic [2:0] bit_cnt;
  logic armed, byte_tgl, bit_tgl, bit_hold, sync_tgl;
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      shift <= 8'h00;
      byte_hold <= 8'h00;
      bit_cnt <= 3'h0;
      armed <= 1'b0;
      byte_tgl <= 1'b0;
    end else if (link_sync_hit) begin
      bit_cnt <= 3'h0;
      armed <= 1'b1;
    end else if (link_bit_valid && armed) begin
      shift <= {shift[6:0], link_bit};
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        byte_hold <= {shift[6:0], link_bit};
        byte_tgl <= ~byte_tgl;
      end
    end
  end
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      bit_hold <= 1'b0;
      bit_tgl <= 1'b0;
      sync_tgl <= 1'b0;
    end else begin
      if (link_bit_valid) begin
        bit_hold <= link_bit;
        bit_tgl <= ~bit_tgl;
      end
      if (link_sync_hit) begin
        sync_tgl <= ~sync_tgl;
      end
    end
  end

  // Crossing into the register clock domain.
  logic [3:0] s1, s2;
  logic [2:0] s3;
  logic bit_ev, byte_ev, sync_ev, raw_data;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 4'h0;
      s2 <= 4'h0;
      s3 <= 3'h0;
    end else if (clk_en) begin
      s1 <= {link_bit, sync_tgl, byte_tgl, bit_tgl};
      s2 <= s1;
      s3 <= s2[2:0];
    end
  end
  assign bit_ev = s2[0] ^ s3[0];
  assign byte_ev = s2[1] ^ s3[1];
  assign sync_ev = s2[2] ^ s3[2];
  assign raw_data = s2[3];

  logic rx, rx_q, rx_enter, rdy_q;
  assign rx = (op_mode == mode_rx);
  assign rx_enter = rx && !rx_q;

  // Recovered bit clock: low at each new bit, high after the low time only with bit sync or packet mode on.
  logic clean_data, dclk;
  logic [2:0] dclk_cnt;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clean_data <= 1'b0;
      dclk <= 1'b0;
      dclk_cnt <= 3'h0;
    end else if (clk_en) begin
      if (bit_ev) begin
        clean_data <= bit_hold;
        dclk <= 1'b0;
        dclk_cnt <= 3'(`RIOM_DCLK_LOW_CYC);
      end else if (dclk_cnt != 3'h0) begin
        dclk_cnt <= dclk_cnt - 3'h1;
        if (dclk_cnt == 3'h1) begin
          dclk <= bit_sync_en || packet_mode;
        end
      end
    end
  end

  // Packet handler.
  riom_state_t state, next_state;
  logic [7:0] remain;
  logic [7:0] crc_hi;
  logic [15:0] crc;
  logic first, wr_en, clr_pkt, done_ev, crc_ok_ev, addr_bad;
  logic unlimited, fmt_var, addr_on;
  logic [7:0] dec_max;
  assign fmt_var = pkt_cfg.frame_format_select;
  assign unlimited = !fmt_var && (pkt_cfg.frame_length_setting == 8'h00);
  assign addr_on = pkt_cfg.addr_check_en && !(unlimited && !pkt_cfg.sync_enable);
  assign dec_max = `RIOM_MSG_MAX_DEC + {7'h00, pkt_cfg.addr_check_en};

  always_comb begin
    next_state = state;
    wr_en = 1'b0;
    clr_pkt = 1'b0;
    done_ev = 1'b0;
    crc_ok_ev = 1'b0;
    addr_bad = 1'b0;
    if (!packet_mode || !rx) begin
      next_state = st_idle;
    end else if (sync_ev) begin
      if (fmt_var) begin
        next_state = st_len;
      end else if (!unlimited && pkt_cfg.decrypt_en && pkt_cfg.frame_length_setting > dec_max) begin
        next_state = st_drop;
      end else begin
        next_state = st_body;
      end
    end else if (byte_ev) begin
      case (state)
        st_len: begin
          wr_en = 1'b1;
          if (byte_hold > pkt_cfg.frame_length_setting || byte_hold == 8'h00 ||
              (pkt_cfg.decrypt_en && byte_hold > dec_max)) begin
            next_state = st_drop;
            clr_pkt = 1'b1;
          end else begin
            next_state = st_body;
          end
        end
        st_body: begin
          wr_en = 1'b1;
          if (first && addr_on && byte_hold != pkt_cfg.node_addr) begin
            addr_bad = 1'b1;
            clr_pkt = 1'b1;
            next_state = st_drop;
          end else if (!unlimited && remain == 8'h01) begin
            if (pkt_cfg.crc_en) begin
              next_state = st_crc;
            end else begin
              done_ev = 1'b1;
              next_state = st_idle;
            end
          end
        end
        st_crc: begin
          if (first) begin
            next_state = st_idle;
            if ({crc_hi, byte_hold} == crc) begin
              crc_ok_ev = 1'b1;
              done_ev = 1'b1;
            end else if (pkt_cfg.crc_autoclear_off) begin
              done_ev = 1'b1;
            end else begin
              clr_pkt = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
      remain <= 8'h00;
      crc <= `RIOM_CRC_INIT;
      crc_hi <= 8'h00;
      first <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      if (sync_ev) begin
        remain <= pkt_cfg.frame_length_setting;
        crc <= `RIOM_CRC_INIT;
        first <= 1'b1;
      end else if (byte_ev) begin
        if (state == st_len) begin
          remain <= byte_hold;
          crc <= crc_step(crc, byte_hold);
        end else if (state == st_body) begin
          remain <= remain - 8'h01;
          crc <= crc_step(crc, byte_hold);
          first <= 1'b0;
        end else if (state == st_crc) begin
          crc_hi <= byte_hold;
          first <= 1'b1;
        end
      end
    end
  end

  // Receive buffer with host read port.
  logic [7:0] mem [66];
  logic [6:0] wr_ptr, rd_ptr, count;
  logic buf_clr, do_wr, do_rd, buf_full, buf_ne, buf_lvl;
  assign buf_full = (count == `RIOM_BUF_DEPTH);
  assign buf_ne = (count != 7'h00);
  assign buf_lvl = (count > pkt_cfg.level_threshold);
  assign buf_clr = (rx_enter && packet_mode) || clr_pkt;
  assign do_wr = wr_en && !buf_full && !buf_clr;
  assign do_rd = rd_req && buf_ne && !buf_clr;

  always_ff @(posedge ref_clk) begin
    if (clk_en && do_wr) begin
      mem[wr_ptr] <= byte_hold;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= 7'h00;
      rd_ptr <= 7'h00;
      count <= 7'h00;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= do_rd;
      if (do_rd) begin
        rd_data <= mem[rd_ptr];
      end
      if (buf_clr) begin
        wr_ptr <= 7'h00;
        rd_ptr <= 7'h00;
        count <= 7'h00;
      end else begin
        if (do_wr) begin
          wr_ptr <= (wr_ptr == `RIOM_BUF_DEPTH - 7'h01) ? 7'h00 : wr_ptr + 7'h01;
        end
        if (do_rd) begin
          rd_ptr <= (rd_ptr == `RIOM_BUF_DEPTH - 7'h01) ? 7'h00 : rd_ptr + 7'h01;
        end
        count <= count + {6'h00, do_wr} - {6'h00, do_rd};
      end
    end
  end

  // Status flags of the framer.
  logic sync_hit, payload_done, crc_pass, data_window;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_q <= 1'b0;
      rdy_q <= 1'b0;
      sync_hit <= 1'b0;
      payload_done <= 1'b0;
      crc_pass <= 1'b0;
      data_window <= 1'b0;
    end else if (clk_en) begin
      rx_q <= rx;
      rdy_q <= status_flags.rx_ready_flag;
      if (!rx) begin
        sync_hit <= 1'b0;
      end else if (sync_ev) begin
        sync_hit <= 1'b1;
      end else if (addr_bad) begin
        sync_hit <= 1'b0;
      end
      if (done_ev && !unlimited) begin
        payload_done <= 1'b1;
      end else if (rx_enter || sync_ev) begin
        payload_done <= 1'b0;
      end
      if (crc_ok_ev && !unlimited) begin
        crc_pass <= 1'b1;
      end else if (rx_enter || sync_ev) begin
        crc_pass <= 1'b0;
      end
      if (status_flags.rx_ready_flag && !rdy_q) begin
        data_window <= 1'b1;
      end else if (done_ev || !rx) begin
        data_window <= 1'b0;
      end
    end
  end

  // Pin sources and registered pin selection.
  logic ser_data;
  logic [16:0] src;
  logic [5:0] pin_q;
  always_comb begin
    if (packet_mode) begin
      ser_data = clean_data && data_window;
    end else begin
      ser_data = bit_sync_en ? clean_data : raw_data;
    end
    src = 17'h0_0000;
    src[sig_clk] = status_flags.clock_output && (op_mode != mode_sleep);
    src[sig_tmo] = status_flags.timeout;
    src[sig_rssi] = status_flags.rssi;
    src[sig_data] = ser_data;
    src[sig_dclk] = dclk && bit_sync_en && !packet_mode;
    src[sig_sync] = sync_hit;
    src[sig_rxrdy] = status_flags.rx_ready_flag;
    src[sig_lbat] = status_flags.low_battery_flag;
    src[sig_auto] = status_flags.automatic_mode_flag;
    src[sig_mrdy] = status_flags.mode_ready_flag;
    src[sig_pll] = status_flags.pll_lock_flag;
    src[sig_ffull] = buf_full;
    src[sig_fne] = buf_ne;
    src[sig_flvl] = buf_lvl;
    src[sig_crc] = crc_pass && !unlimited;
    src[sig_pdone] = payload_done && !unlimited;
  end

  genvar g;
  for (g = 0; g < `RIOM_PINS; g++) begin : g_pin
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        pin_q[g] <= 1'b0;
      end else if (clk_en) begin
        pin_q[g] <= src[pin_sel(g, map_code(g, io_map_reg_1, io_map_reg_2), op_mode, packet_mode)];
      end
    end
  end

  assign io_pin_0 = pin_q[0];
  assign io_pin_1 = pin_q[1];
  assign io_pin_2 = pin_q[2];
  assign io_pin_3 = pin_q[3];
  assign io_pin_4 = pin_q[4];
  assign io_pin_5 = pin_q[5];

endmodule

// ### pkg/riom_map.svh
// Constants for the receive IO mapping and packet framer.
`ifndef RIOM_MAP_SVH
`define RIOM_MAP_SVH

`define RIOM_PINS 6
`define RIOM_BUF_DEPTH 7'h42
`define RIOM_MSG_MAX_DEC 8'h40
`define RIOM_CRC_POLY 16'h1021
`define RIOM_CRC_INIT 16'hFFFF
`define RIOM_MAP_TOP 7
`define RIOM_CLK_PERIOD_NS 25
`define RIOM_DCLK_LOW_NS 50
`define RIOM_DCLK_LOW_CYC ((`RIOM_DCLK_LOW_NS + `RIOM_CLK_PERIOD_NS - 1) / `RIOM_CLK_PERIOD_NS)

`endif

// ### pkg/riom_pkg.sv
// Types shared by the receive IO mapping and packet framer.
package riom_pkg;

  typedef enum logic [1:0] {
    mode_sleep = 2'h0,
    mode_stdby = 2'h1,
    mode_fs = 2'h2,
    mode_rx = 2'h3
  } riom_mode_t;

  typedef enum logic [4:0] {
    sig_none = 5'h00,
    sig_clk = 5'h01,
    sig_tmo = 5'h02,
    sig_rssi = 5'h03,
    sig_data = 5'h04,
    sig_dclk = 5'h05,
    sig_sync = 5'h06,
    sig_rxrdy = 5'h07,
    sig_lbat = 5'h08,
    sig_auto = 5'h09,
    sig_mrdy = 5'h0a,
    sig_pll = 5'h0b,
    sig_ffull = 5'h0c,
    sig_fne = 5'h0d,
    sig_flvl = 5'h0e,
    sig_crc = 5'h0f,
    sig_pdone = 5'h10
  } riom_sig_t;

  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_len = 5'h02,
    st_body = 5'h04,
    st_crc = 5'h08,
    st_drop = 5'h10
  } riom_state_t;

  typedef struct packed {
    logic low_battery_flag;
    logic automatic_mode_flag;
    logic mode_ready_flag;
    logic pll_lock_flag;
    logic rx_ready_flag;
    logic timeout;
    logic rssi;
    logic clock_output;
  } riom_flags_t;

  typedef struct packed {
    logic frame_format_select;
    logic [7:0] frame_length_setting;
    logic sync_enable;
    logic addr_check_en;
    logic [7:0] node_addr;
    logic crc_en;
    logic crc_autoclear_off;
    logic decrypt_en;
    logic [6:0] level_threshold;
  } riom_pkt_cfg_t;

endpackage

// ### tb/riom_core_monitor.sv
// Checker for the pin mapping and read handshake of the receive block.
`timescale 1ns/100ps
module riom_core_monitor import riom_pkg::*; (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire riom_mode_t op_mode,
  input wire logic packet_mode,
  input wire logic bit_sync_en,
  input wire logic [7:0] io_map_reg_1,
  input wire logic [7:0] io_map_reg_2,
  input wire riom_flags_t status_flags,
  input wire riom_pkt_cfg_t pkt_cfg,
  input wire logic rd_req,
  input wire logic rd_valid,
  input wire logic io_pin_0,
  input wire logic io_pin_1,
  input wire logic io_pin_4,
  input wire logic io_pin_5
);
  logic [1:0] up;
  logic rdy;
  logic crx;
  logic prx;
  logic unl;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      up <= 2'h0;
    end else if (up != 2'h3) begin
      up <= up + 2'h1;
    end
  end
  assign rdy = up == 2'h3 && clk_en;
  assign crx = rdy && !packet_mode && op_mode == mode_rx;
  assign prx = rdy && packet_mode && op_mode == mode_rx;
  assign unl = prx && !pkt_cfg.frame_format_select && pkt_cfg.frame_length_setting == 8'h00 && io_map_reg_1[7:6] == 2'h1;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  idle_lbat_a: assert property (
    rdy && !packet_mode && op_mode != mode_rx && io_map_reg_2[5:4] == 2'h2
    |=> io_pin_5 == $past(status_flags.low_battery_flag)) else $error("pin 5 not low battery");
  crx_tmo_a: assert property (
    crx && io_map_reg_1[7:6] == 2'h1 |=> io_pin_0 == $past(status_flags.timeout)) else $error("pin 0 not timeout");
  crx_mrdy_a: assert property (
    crx && io_map_reg_2[5:4] == 2'h3 |=> io_pin_5 == $past(status_flags.mode_ready_flag)) else $error("pin 5 not ready");
  prx_tmo_a: assert property (
    prx && io_map_reg_2[7:6] == 2'h0 |=> io_pin_4 == $past(status_flags.timeout)) else $error("pin 4 not timeout");
  prx_rssi_a: assert property (
    prx && io_map_reg_1[7:6] == 2'h3 |=> io_pin_0 == $past(status_flags.rssi)) else $error("pin 0 not rssi");
  psleep_lbat_a: assert property (
    rdy && packet_mode && op_mode == mode_sleep && io_map_reg_1[7:6] == 2'h2
    |=> io_pin_0 == $past(status_flags.low_battery_flag)) else $error("pin 0 not low battery");
  unmapped_low_a: assert property (
    rdy && !packet_mode && op_mode != mode_rx && io_map_reg_1[7:6] == 2'h1 |=> !io_pin_0) else $error("pin 0 not low");
  no_dclk_a: assert property (
    crx && !bit_sync_en && io_map_reg_1[5:4] == 2'h0 |=> !io_pin_1) else $error("bit clock without sync");
  unl_done_a: assert property (
    unl [*3] |=> !$rose(io_pin_0)) else $error("done flag in unlimited format");
  read_cause_a: assert property (
    rd_valid && $past(clk_en) |-> $past(rd_req)) else $error("read data without request");
  cover property (prx && io_pin_0);
  cover property (rd_valid);
  cover property (crx && io_pin_1);
endmodule

bind riom_core riom_core_monitor mon (.ref_clk, .resetn, .clk_en, .op_mode, .packet_mode, .bit_sync_en,
  .io_map_reg_1, .io_map_reg_2, .status_flags, .pkt_cfg, .rd_req, .rd_valid, .io_pin_0, .io_pin_1, .io_pin_4,
  .io_pin_5);

// ### tb/riom_core_test.sv
// Self-checking bench for the receive mapping and packet framer.
`timescale 1ns/100ps
`include "riom_map.svh"
module riom_core_test import riom_pkg::*;;
  typedef struct packed {
    riom_mode_t mode;
    logic pkt;
    logic [1:0] code;
    logic [7:0] flags;
    logic [5:0] exp;
  } riom_row_t;
  typedef struct packed {
    logic fmt;
    logic [7:0] lset;
    logic achk;
    logic dec;
    logic [7:0] first;
    logic [7:0] n;
    logic [7:0] exp_n;
    logic done;
  } riom_prow_t;
  logic ref_clk, resetn, clk_en, packet_mode, bit_sync_en, rd_req, rd_valid, got;
  logic link_clk, link_bit, link_bit_valid, link_sync_hit;
  logic [7:0] io_map_reg_1, io_map_reg_2, rd_data, d;
  wire [5:0] pins;
  riom_mode_t op_mode;
  riom_flags_t status_flags;
  riom_pkt_cfg_t pkt_cfg;
  int fail_count, n_compared, cnt;
  logic [15:0] crc;
  riom_row_t rows [19] = '{
    '{mode_sleep, 1'b0, 2'h2, 8'hff, 6'h3b}, '{mode_sleep, 1'b0, 2'h0, 8'hff, 6'h00},
    '{mode_stdby, 1'b0, 2'h0, 8'hff, 6'h20}, '{mode_stdby, 1'b0, 2'h3, 8'h20, 6'h21},
    '{mode_fs, 1'b0, 2'h3, 8'h10, 6'h12}, '{mode_fs, 1'b0, 2'h0, 8'h11, 6'h21}, '{mode_fs, 1'b0, 2'h1, 8'hff, 6'h00},
    '{mode_rx, 1'b0, 2'h1, 8'h0a, 6'h3a}, '{mode_rx, 1'b0, 2'h0, 8'h05, 6'h30},
    '{mode_rx, 1'b0, 2'h2, 8'hc2, 6'h2b}, '{mode_rx, 1'b0, 2'h3, 8'h34, 6'h39},
    '{mode_sleep, 1'b1, 2'h2, 8'hff, 6'h3d}, '{mode_stdby, 1'b1, 2'h3, 8'h40, 6'h04},
    '{mode_fs, 1'b1, 2'h3, 8'h30, 6'h3b}, '{mode_stdby, 1'b1, 2'h0, 8'h01, 6'h20},
    '{mode_sleep, 1'b1, 2'h1, 8'hff, 6'h00}, '{mode_rx, 1'b1, 2'h3, 8'h16, 6'h1b},
    '{mode_rx, 1'b1, 2'h0, 8'h05, 6'h30}, '{mode_rx, 1'b1, 2'h2, 8'h88, 6'h34}};
  riom_prow_t prows [9] = '{
    '{1'b1, 8'h0a, 1'b0, 1'b0, 8'h03, 8'h04, 8'h04, 1'b1}, '{1'b1, 8'h02, 1'b0, 1'b0, 8'h03, 8'h04, 8'h00, 1'b0},
    '{1'b0, 8'h02, 1'b0, 1'b0, 8'h33, 8'h02, 8'h02, 1'b1}, '{1'b0, 8'h02, 1'b1, 1'b0, 8'h33, 8'h02, 8'h00, 1'b0},
    '{1'b0, 8'h02, 1'b1, 1'b0, 8'h5a, 8'h02, 8'h02, 1'b1}, '{1'b1, 8'hff, 1'b0, 1'b1, 8'h41, 8'h02, 8'h00, 1'b0},
    '{1'b0, 8'h41, 1'b0, 1'b1, 8'h33, 8'h02, 8'h00, 1'b0}, '{1'b0, 8'h00, 1'b0, 1'b0, 8'h33, 8'h03, 8'h03, 1'b0},
    '{1'b0, 8'h00, 1'b0, 1'b0, 8'h33, 8'h46, 8'h42, 1'b0}};
  riom_core dut (.ref_clk, .resetn, .clk_en, .op_mode, .packet_mode, .bit_sync_en, .io_map_reg_1, .io_map_reg_2,
    .status_flags, .pkt_cfg, .rd_req, .rd_data, .rd_valid, .io_pin_0(pins[0]), .io_pin_1(pins[1]), .io_pin_2(pins[2]),
    .io_pin_3(pins[3]), .io_pin_4(pins[4]), .io_pin_5(pins[5]), .link_clk, .link_bit, .link_bit_valid, .link_sync_hit);
  riom_host host (.ref_clk, .io_pin_1(pins[1]), .io_pin_2(pins[2]), .rd_valid, .rd_data, .rd_req);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #5;
    forever begin
      link_clk = ~link_clk;
      #15;
    end
  end
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(negedge link_clk);
      link_bit = b[i];
      link_bit_valid = 1'b1;
      @(negedge link_clk);
      link_bit_valid = 1'b0;
      repeat (10) @(negedge link_clk);
    end
  endtask
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[15] ^ b[i];
      r = {r[14:0], 1'b0} ^ (fb ? `RIOM_CRC_POLY : 16'h0000);
    end
    return r;
  endfunction
  task automatic open_frame(input riom_pkt_cfg_t c);
    @(negedge ref_clk);
    op_mode = mode_stdby;
    packet_mode = 1'b1;
    io_map_reg_1 = 8'h40;
    pkt_cfg = c;
    @(negedge ref_clk);
    op_mode = mode_rx;
    repeat (4) @(negedge link_clk);
    link_sync_hit = 1'b1;
    @(negedge link_clk);
    link_sync_hit = 1'b0;
  endtask
  initial begin
    #1000000;
    fail_count++;
    wrap_up();
  end
  initial begin
    fail_count = 0;
    n_compared = 0;
    resetn = 1'b0;
    clk_en = 1'b1;
    op_mode = mode_stdby;
    packet_mode = 1'b0;
    bit_sync_en = 1'b0;
    io_map_reg_1 = 8'haa;
    io_map_reg_2 = 8'ha0;
    status_flags = 8'hff;
    pkt_cfg = '0;
    link_bit = 1'b0;
    link_bit_valid = 1'b0;
    link_sync_hit = 1'b0;
    repeat (3) @(negedge ref_clk);
    check({2'h0, pins}, 8'h00);
    resetn = 1'b1;
    repeat (3) @(negedge ref_clk);
    pkt_cfg.level_threshold = 7'h10;
    foreach (rows[i]) begin
      @(negedge ref_clk);
      op_mode = rows[i].mode;
      packet_mode = rows[i].pkt;
      io_map_reg_1 = {4{rows[i].code}};
      io_map_reg_2 = {rows[i].code, rows[i].code, 4'h0};
      status_flags = rows[i].flags;
      @(negedge ref_clk);
      check({2'h0, pins}, {2'h0, rows[i].exp});
    end
    @(negedge ref_clk);
    clk_en = 1'b0;
    status_flags = 8'h00;
    repeat (2) @(negedge ref_clk);
    check({2'h0, pins}, 8'h34);
    clk_en = 1'b1;
    @(negedge ref_clk);
    packet_mode = 1'b0;
    bit_sync_en = 1'b1;
    io_map_reg_1 = 8'h00;
    send_byte(8'ha5);
    repeat (10) @(negedge ref_clk);
    check(host.shreg, 8'ha5);
    bit_sync_en = 1'b0;
    cnt = host.dclk_cnt;
    send_byte(8'h3d);
    repeat (10) @(negedge ref_clk);
    check(8'(host.dclk_cnt - cnt), 8'h00);
    check({7'h0, pins[2]}, 8'h01);
    foreach (prows[i]) begin
      open_frame('{prows[i].fmt, prows[i].lset, 1'b1, prows[i].achk, 8'h5a, 1'b0, 1'b0, prows[i].dec, 7'h10});
      for (int j = 0; j < prows[i].n; j++) begin
        send_byte(j == 0 ? prows[i].first : 8'h40 + 8'(j));
      end
      repeat (20) @(negedge ref_clk);
      check({7'h0, pins[0]}, {7'h0, prows[i].done});
      op_mode = mode_stdby;
      for (int j = 0; j <= prows[i].exp_n; j++) begin
        host.read_byte(got, d);
        check({7'h0, got}, {7'h0, j < prows[i].exp_n});
        if (j < prows[i].exp_n) begin
          check(d, j == 0 ? prows[i].first : 8'h40 + 8'(j));
        end
      end
    end
    for (int k = 0; k < 2; k++) begin
      open_frame('{1'b0, 8'h02, 1'b1, 1'b0, 8'h5a, 1'b1, 1'b0, 1'b0, 7'h10});
      crc = crc16(crc16(`RIOM_CRC_INIT, 8'h33), 8'h41);
      send_byte(8'h33);
      send_byte(8'h41);
      send_byte(crc[15:8]);
      send_byte(crc[7:0] ^ 8'(k));
      repeat (20) @(negedge ref_clk);
      check({7'h0, pins[0]}, {7'h0, k == 0});
      op_mode = mode_stdby;
      host.read_byte(got, d);
      check({7'h0, got}, {7'h0, k == 0});
      if (k == 0) begin
        check(d, 8'h33);
      end
    end
    wrap_up();
  end
endmodule

// ### tb/riom_host.sv
// Host model that reads the receive buffer and samples clocked data.
`timescale 1ns/100ps
module riom_host (
  input wire logic ref_clk,
  input wire logic io_pin_1,
  input wire logic io_pin_2,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  output logic rd_req
);
  logic [7:0] shreg;
  int dclk_cnt;
  initial begin
    rd_req = 1'b0;
    shreg = 8'h00;
    dclk_cnt = 0;
  end
  always @(posedge io_pin_1) begin
    shreg <= {shreg[6:0], io_pin_2};
    dclk_cnt <= dclk_cnt + 1;
  end
  task automatic read_byte(output logic got, output logic [7:0] d);
    @(negedge ref_clk);
    rd_req = 1'b1;
    @(negedge ref_clk);
    rd_req = 1'b0;
    got = rd_valid;
    d = rd_data;
  endtask
endmodule
